// File: rtl/strap_map.vh
// Constants for the strap decoder and bank address selection.
`ifndef STRAP_LOADER_MAP_VH
`define STRAP_LOADER_MAP_VH

// ----------------------------------------
// Four-level codes
// ----------------------------------------
`define LVL_L0            2'h0
`define LVL_L1            2'h1
`define LVL_L2            2'h2
`define LVL_L3            2'h3

// ----------------------------------------
// Mode strap decode
// ----------------------------------------
`define MODE_PIN_CTRL     2'h0
`define MODE_CONTROLLER   2'h1
`define MODE_TARGET       2'h2
`define MODE_RESERVED     2'h3

// ----------------------------------------
// Target address map
// ----------------------------------------
`define ADDR_BASE         7'h18
`define ADDR_BANK_HI_BIT  0
`define ADDR_W            7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS     8
`define SETTLE_TIME_NS    1000
`define SETTLE_CYC        ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W      8
`define STABLE_TIME_NS    256
`define STABLE_CYC        ((`STABLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STABLE_CNT_W      6

// ----------------------------------------
// Loader states, one-hot
// ----------------------------------------
`define ST_W              4
`define ST_WAIT_POR       4'h1
`define ST_SETTLE         4'h2
`define ST_CAPTURE        4'h4
`define ST_LOCKED         4'h8

`endif

// File: rtl/level_resolver.v
// Resolves one four-level strap pin, seen as a comparator thermometer, into a level code.
`timescale 1ns/1ns
`default_nettype none
`include "strap_map.vh"

module level_resolver (
	// Clock and reset
	input  wire       clk_sys_in,
	input  wire       resetn_in,
	// Comparator thermometer from the pin divider
	input  wire [2:0] thermo_in,
	// Resolved level
	output reg  [1:0] level_out,
	output reg        stable_out
);

	reg  [2:0]                 thermo_meta;
	reg  [2:0]                 thermo_sync;
	reg  [1:0]                 last_code;
	reg  [`STABLE_CNT_W-1:0]   stable_cnt;
	wire [1:0]                 next_code;

	// The code is the count of tripped comparators only for a clean thermometer; any other pattern reads as L0, and a float reads as L3.
	// level decode
	assign next_code = (thermo_sync == 3'h7) ? `LVL_L3 :
	                   (thermo_sync == 3'h3) ? `LVL_L2 :
	                   (thermo_sync == 3'h1) ? `LVL_L1 : `LVL_L0;

	// The pin is asynchronous; the first stage feeds only the second.
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			thermo_meta <= 3'h0;
			thermo_sync <= 3'h0;
		end else begin
			thermo_meta <= thermo_in;
			thermo_sync <= thermo_meta;
		end
	end

	// A level counts as resolved only once it has held for the stable time,
	// which hides the divider's charging edge after power up.
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			last_code  <= `LVL_L0;
			stable_cnt <= {`STABLE_CNT_W{1'b0}};
			level_out  <= `LVL_L0;
			stable_out <= 1'b0;
		end else if (next_code != last_code) begin
			last_code  <= next_code;
			stable_cnt <= {`STABLE_CNT_W{1'b0}};
			stable_out <= 1'b0;
		end else if ({{(32-`STABLE_CNT_W){1'b0}}, stable_cnt} == `STABLE_CYC) begin
			level_out  <= last_code;
			stable_out <= 1'b1;
		end else begin
			stable_cnt <= stable_cnt + {{(`STABLE_CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule // level_resolver

`default_nettype wire

// File: rtl/strap_loader.v
// Power-up strap loader: operating mode and the two bank target addresses.
`timescale 1ns/1ns
`default_nettype none
`include "strap_map.vh"


module strap_loader (
	// Clock and reset
	input  wire                clk_sys_in,
	input  wire                resetn_in,
	// Internal power-on reset, high once released
	input  wire                por_done_in,
	// Strap comparator thermometers
	input  wire [2:0]          mode_strap_in,
	input  wire [2:0]          address_strap_upper_in,
	input  wire [2:0]          address_strap_lower_in,
	// Seven-bit address from the SMBus target engine
	input  wire                addr_valid_in,
	input  wire [`ADDR_W-1:0]  addr_in,
	// Mode outputs
	output reg  [1:0]          mode_code_out,
	output reg                 mode_pin_ctrl_out,
	output reg                 mode_controller_out,
	output reg                 mode_target_out,
	output reg                 mode_reserved_out,
	// Bank addresses
	output reg  [`ADDR_W-1:0]  low_bank_addr_out,
	output reg  [`ADDR_W-1:0]  high_bank_addr_out,
	output reg                 straps_valid_out,
	// Address match
	output reg                 addr_hit_out,
	output reg                 addr_bank_out
);

	// ----------------------------------------
	// Strap resolvers
	// ----------------------------------------
	wire [8:0]                 thermo_all;
	wire [5:0]                 level_all;
	wire [2:0]                 stable_all;

	assign thermo_all = {address_strap_lower_in, address_strap_upper_in, mode_strap_in};

	// One resolver per strap pin.
	// Each resolver filters its own pin; the loader waits for all three.
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_strap
			level_resolver u_res (
				.clk_sys_in (clk_sys_in),
				.resetn_in  (resetn_in),
				.thermo_in  (thermo_all[3*g+2:3*g]),
				.level_out  (level_all[2*g+1:2*g]),
				.stable_out (stable_all[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Power-on reset synchroniser
	// ----------------------------------------
	reg                        por_meta;
	reg                        por_sync;

	// The power-on reset indicator comes from the supply supervisor, not from
	// this clock, so it is treated like a pin.
	// The first stage is read by the second and nothing else.
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			por_meta <= 1'b0;
			por_sync <= 1'b0;
		end else begin
			por_meta <= por_done_in;
			por_sync <= por_meta;
		end
	end

	// ----------------------------------------
	// Loader state machine
	// ----------------------------------------
	reg  [`ST_W-1:0]           state;
	reg  [`ST_W-1:0]           next_state;
	reg  [`SETTLE_CNT_W-1:0]   settle_cnt;
	wire                       settle_done;

	// The counter is widened to the 32 bits of the cycle count, so the compare
	// stays exact for any settle time that fits the counter.
	assign settle_done = ({{(32-`SETTLE_CNT_W){1'b0}}, settle_cnt} == `SETTLE_CYC);

	// A power-on reset that drops during the settle time sends the loader back
	// to waiting, so a supply glitch cannot capture half-charged straps.
	// Sampling waits for the power-on reset, then a settle time, then all
	// resolvers stable. Once locked nothing leaves except a reset.
	always @* begin
		next_state = state;
		case (state)
			`ST_WAIT_POR: begin
				if (por_sync)
					next_state = `ST_SETTLE;
			end
			`ST_SETTLE: begin
				if (!por_sync)
					next_state = `ST_WAIT_POR;
				else if (settle_done && (&stable_all))
					next_state = `ST_CAPTURE;
			end
			`ST_CAPTURE: begin
				next_state = `ST_LOCKED;
			end
			`ST_LOCKED: begin
				next_state = `ST_LOCKED;
			end
			default: begin
				next_state = `ST_WAIT_POR;
			end
		endcase
	end

	// State register and settle counter.
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state      <= `ST_WAIT_POR;
			settle_cnt <= {`SETTLE_CNT_W{1'b0}};
		end else begin
			state <= next_state;
			if (state != `ST_SETTLE)
				settle_cnt <= {`SETTLE_CNT_W{1'b0}};
			else if (!settle_done)
				settle_cnt <= settle_cnt + {{(`SETTLE_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// ----------------------------------------
	// Address computation
	// ----------------------------------------
	wire [1:0]                 mode_lvl;
	wire [1:0]                 upper_lvl;
	wire [1:0]                 lower_lvl;
	wire [`ADDR_W-1:0]         next_low_addr;

	assign mode_lvl  = level_all[1:0];
	assign upper_lvl = level_all[3:2];
	assign lower_lvl = level_all[5:4];

	// The sum never carries past bit 5: the largest low address is the base
	// plus thirty, which still leaves the high bank inside the map.
	// Upper level lands in bits 4:3 and lower level in bits 2:1.
	// address formula
	assign next_low_addr = `ADDR_BASE + {2'h0, upper_lvl, lower_lvl, 1'b0};

	// ----------------------------------------
	// Captured configuration
	// ----------------------------------------
	// Before capture the mode flags read all zero, which downstream logic takes
	// as no mode selected yet rather than as pin control.
	// Captured once in the capture state; later strap motion is ignored,
	// so a bumped resistor cannot move the device on the bus mid-run.
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mode_code_out       <= `MODE_PIN_CTRL;
			mode_pin_ctrl_out   <= 1'b0;
			mode_controller_out <= 1'b0;
			mode_target_out     <= 1'b0;
			mode_reserved_out   <= 1'b0;
			low_bank_addr_out   <= `ADDR_BASE;
			high_bank_addr_out  <= `ADDR_BASE;
			straps_valid_out    <= 1'b0;
		end else if (state == `ST_CAPTURE) begin
			mode_code_out       <= mode_lvl;
			mode_pin_ctrl_out   <= (mode_lvl == `MODE_PIN_CTRL);
			mode_controller_out <= (mode_lvl == `MODE_CONTROLLER);
			mode_target_out     <= (mode_lvl == `MODE_TARGET);
			mode_reserved_out   <= (mode_lvl == `MODE_RESERVED);
			low_bank_addr_out   <= next_low_addr;
			// The low address is always even, so setting bit 0 adds one.
			high_bank_addr_out  <= next_low_addr | {{(`ADDR_W-1){1'b0}}, 1'b1};
			straps_valid_out    <= 1'b1;
		end
	end

	// ----------------------------------------
	// Target address match
	// ----------------------------------------
	// The engine offers one address per valid pulse; an offer in the next
	// cycle gets its own answer, so back-to-back offers need no spacing.
	// The bank flag keeps its value between hits for the register decoder.
	// A hit is a one-cycle pulse naming the bank; addresses are answered only
	// in target mode after capture, since before then they are not yet known.
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			addr_hit_out  <= 1'b0;
			addr_bank_out <= 1'b0;
		end else begin
			addr_hit_out <= 1'b0;
			if (addr_valid_in && straps_valid_out && mode_target_out) begin
				if (addr_in == low_bank_addr_out) begin
					addr_hit_out  <= 1'b1;
					addr_bank_out <= 1'b0;
				end else if (addr_in == high_bank_addr_out) begin
					addr_hit_out  <= 1'b1;
					addr_bank_out <= 1'b1;
				end
			end
		end
	end

endmodule // strap_loader

`default_nettype wire

// File: verification/smbus_host_model.sv
// Host model that offers SMBus target addresses to the strap loader.
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
	// Clock
	input  wire logic       clk_sys_in,
	// Address offer
	output var  logic       addr_valid_out,
	output var  logic [6:0] addr_out
);
	initial begin
		addr_valid_out = 1'b0;
		addr_out = 7'h00;
	end
	// single host, unique targets.
	// The address is inverted once released so a stale match cannot pass by accident.
	task automatic send(input logic [6:0] a);
		@(posedge clk_sys_in);
		addr_valid_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_sys_in);
		addr_valid_out <= 1'b0;
		addr_out <= ~a;
		#1;
	endtask
endmodule // smbus_host_model
`default_nettype wire

// File: verification/strap_loader_chk.sv
// Port-level assertions for the strap loader.
`timescale 1ns/1ns
`default_nettype none
module strap_loader_chk (
	input wire logic       clk_sys_in, resetn_in, por_done_in, addr_valid_in,
	input wire logic [2:0] mode_strap_in, address_strap_upper_in, address_strap_lower_in,
	input wire logic [6:0] addr_in, low_bank_addr_out, high_bank_addr_out,
	input wire logic [1:0] mode_code_out,
	input wire logic       mode_pin_ctrl_out, mode_controller_out, mode_target_out,
	input wire logic       mode_reserved_out, straps_valid_out, addr_hit_out, addr_bank_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	logic [7:0] por_cnt;
	wire        lk = addr_valid_in && straps_valid_out && mode_target_out &&
		(addr_in == low_bank_addr_out || addr_in == high_bank_addr_out);
	// Counts cycles since the power-on reset released, saturating.
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in || !por_done_in) por_cnt <= 8'h00;
		else if (por_cnt != 8'hff) por_cnt <= por_cnt + 8'h01;
	end
	a_hit_cause: assert property (addr_hit_out |-> $past(lk))
		else $error("hit without a matching offer");
	a_hit_answer: assert property (lk |=> addr_hit_out &&
		addr_bank_out == $past(addr_in == high_bank_addr_out)) else $error("bad hit or bank");
	a_pair_step: assert property (straps_valid_out |->
		high_bank_addr_out == low_bank_addr_out + 7'h01) else $error("high not low plus one");
	a_low_range: assert property (straps_valid_out |-> !low_bank_addr_out[0] &&
		low_bank_addr_out >= 7'h18 && low_bank_addr_out <= 7'h36) else $error("low out of map");
	a_mode_decode: assert property (straps_valid_out |-> {mode_reserved_out,
		mode_target_out, mode_controller_out, mode_pin_ctrl_out} == 4'h1 << mode_code_out)
		else $error("mode flags disagree with code");
	a_idle_state: assert property (!straps_valid_out |-> low_bank_addr_out == 7'h18 &&
		high_bank_addr_out == 7'h18 && mode_code_out == 2'h0 && !mode_target_out)
		else $error("outputs moved before capture");
	a_capture_held: assert property (straps_valid_out |=> straps_valid_out &&
		$stable(low_bank_addr_out) && $stable(mode_code_out)) else $error("capture changed");
	a_por_first: assert property ($rose(straps_valid_out) |-> por_cnt >= 8'd100)
		else $error("capture too soon after power-on reset");
endmodule // strap_loader_chk
bind strap_loader strap_loader_chk strap_loader_chk_i (.clk_sys_in, .resetn_in, .por_done_in,
	.addr_valid_in, .mode_strap_in, .address_strap_upper_in, .address_strap_lower_in, .addr_in,
	.low_bank_addr_out, .high_bank_addr_out, .mode_code_out, .mode_pin_ctrl_out,
	.mode_controller_out, .mode_target_out, .mode_reserved_out, .straps_valid_out,
	.addr_hit_out, .addr_bank_out);
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench for the strap loader.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic       clk = 0, rstn = 0, por = 0;
	logic [2:0] ms = 0, su = 0, sl = 0;
	wire        av, m_pin, m_ctl, m_tgt, m_res, svalid, hit, bank;
	wire  [6:0] ad, lo_a, hi_a;
	wire  [1:0] mcode;
	int         num_errors = 0, n_compared = 0;
	initial forever #4 clk = ~clk;
	strap_loader strap_loader_i (.clk_sys_in(clk), .resetn_in(rstn), .por_done_in(por),
		.mode_strap_in(ms), .address_strap_upper_in(su), .address_strap_lower_in(sl),
		.addr_valid_in(av), .addr_in(ad), .mode_code_out(mcode), .mode_pin_ctrl_out(m_pin),
		.mode_controller_out(m_ctl), .mode_target_out(m_tgt), .mode_reserved_out(m_res),
		.low_bank_addr_out(lo_a), .high_bank_addr_out(hi_a), .straps_valid_out(svalid),
		.addr_hit_out(hit), .addr_bank_out(bank));
	smbus_host_model smbus_host_model_i (.clk_sys_in(clk), .addr_valid_out(av), .addr_out(ad));
	// Thermometer pattern that a pin divider gives for a level.
	function automatic logic [2:0] th(input int l);
		return {l > 2, l > 1, l > 0};
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Resets, sets the straps, releases power-on reset and waits for the capture.
	task automatic power_up(input int m, input int u, input int l);
		int i;
		@(posedge clk);
		rstn <= 0;
		por <= 0;
		ms <= th(m);
		su <= th(u);
		sl <= th(l);
		repeat (16) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		por <= 1;
		for (i = 0; i < 400 && svalid !== 1'b1; i++) @(posedge clk);
		if (i == 400) begin
			num_errors++;
			conclude();
		end
		#1;
	endtask
	// Offers one address and judges the answer one cycle later.
	task automatic offer(input logic [6:0] a, input logic h, input logic b);
		smbus_host_model_i.send(a);
		check("hit", hit, h);
		if (h) check("bank", bank, b);
	endtask
	// Holding power-on reset keeps the straps unsampled however long it lasts.
	task automatic t_por_gate();
		@(posedge clk);
		rstn <= 0;
		ms <= th(2);
		repeat (16) @(posedge clk);
		rstn <= 1;
		repeat (300) @(posedge clk);
		#1 check("valid", svalid, 0);
		$display("test por_gate done");
	endtask
	task automatic t_addr_map();
		logic [6:0] e;
		for (int u = 0; u < 4; u++) for (int l = 0; l < 4; l++) begin
			e = 7'h18 + 7'(8 * u + 2 * l);
			power_up(2, u, l);
			check("low", lo_a, e);
			check("high", hi_a, e + 7'h01);
			offer(e, 1, 0);
			offer(e + 7'h01, 1, 1);
		end
		$display("test addr_map done");
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			power_up(m, 3, 3);
			check("mode", mcode, m);
			check("flags", {m_res, m_tgt, m_ctl, m_pin}, 8'h1 << m);
			offer(7'h37, m == 2, 1);
		end
		$display("test modes done");
	endtask
	// Straps moved after capture must not change the addresses or the answers.
	task automatic t_hold();
		power_up(2, 1, 2);
		@(posedge clk);
		ms <= th(0);
		su <= th(3);
		sl <= th(3);
		repeat (300) @(posedge clk);
		#1 check("held", lo_a, 8'h24);
		check("mode", mcode, 2);
		offer(7'h36, 0, 0);
		offer(7'h40, 0, 0);
		offer(7'h25, 1, 1);
		$display("test hold done");
	endtask
	initial begin
		t_por_gate();
		t_addr_map();
		t_modes();
		t_hold();
		conclude();
	end
endmodule // tb_top
`default_nettype wire
